/* src/pmi_pkg.sv */
package pmi_pkg;
  localparam int           PMI_NUM_REGS  = 10;
  localparam int           PMI_IDX_W     = 4;
  localparam logic [6:0]   PMI_DEV_ADDR  = 7'h3e;
  localparam logic [7:0]   PMI_ID_PTR    = 8'h46;
  localparam logic [3:0]   PMI_BYTE_BITS = 4'h8;
  localparam logic [7:0]   PMI_PTR_STEP  = 8'h01;
  localparam logic [3:0]   PMI_CNT_ZERO  = 4'h0;
  localparam logic [3:0]   PMI_CNT_STEP  = 4'h1;
  // clock figures, for reference; no check reads them
  localparam int           PMI_SYS_PER_NS = 5;
  localparam int           PMI_LNK_PER_NS = 15;

  typedef logic [PMI_NUM_REGS-1:0][7:0] pmi_regs_type;

  // index 9 first: ldo5..ldo1, buck, ramp, ls time, discharge, on/off
  localparam pmi_regs_type PMI_REG_RST = {
    8'h02, 8'h16, 8'h11, 8'h0e, 8'h0c,
    8'h02, 8'h09, 8'h08, 8'hff, 8'h01};

  typedef enum logic [1:0] {PMI_K_ADDR, PMI_K_PTR, PMI_K_DATA}
    pmi_kind_type;

  typedef enum logic [2:0] {
    PMI_S_IDLE, PMI_S_RX, PMI_S_ACK, PMI_S_TX, PMI_S_MACK
  } pmi_state_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } pmi_bus_in_type;

  typedef struct packed {
    logic sda_o;
    logic sda_oe;
  } pmi_pin_type;

  typedef struct packed {
    pmi_regs_type regs;
    logic         en;
  } pmi_out_type;
endpackage

/* src/pmi_port.sv */
// Contract
// - answer only bus address 0111110
// - acknowledge own address on ninth clock
// - bytes move msb first, one per clock
// - data changes only while clock low
// - idle bus leaves both lines released
// - slave only, never drives clock
// - receiver holds data low on ninth
// - device drives ack for master writes
// - acknowledge every pointer value
// - write register before data acknowledge
// - block write auto increments pointer
// - lockout disables outputs, resets registers
// - read returns pointed register after restart
// - master ack increments pointer, sends next
module pmi_port #(
  parameter logic [7:0] ID_VAL = 8'h5a  // arbitrary die code
) (
  // system side
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               uvlo,
  output pmi_pkg::pmi_out_type    ctrl,
  // link side
  input  wire logic               clk_link,
  input  pmi_pkg::pmi_bus_in_type lines,
  output pmi_pkg::pmi_pin_type    drive
);
  import pmi_pkg::*;

  typedef struct packed {
    logic [1:0]    scl_s;
    logic [1:0]    sda_s;
    logic [1:0]    rst_s;
    logic [1:0]    uvlo_s;
    logic [1:0]    ack_s;
    logic          scl_p;
    logic          sda_p;
    pmi_state_type state;
    pmi_kind_type  kind;
    logic          rw;
    logic          mack;
    logic [3:0]    cnt;
    logic [7:0]    sh;
    logic [7:0]    ptr;
    pmi_regs_type  regs;
    pmi_regs_type  hold;
    logic          req;
    pmi_pin_type   pin;
  } pmi_lnk_type;

  typedef struct packed {
    logic [1:0]  req_s;
    logic [1:0]  uvlo_s;
    logic        ack;
    pmi_out_type out;
  } pmi_sys_type;

  localparam pmi_sys_type PMI_SYS_RST = '{
    req_s: 2'h0, uvlo_s: 2'h0, ack: 1'b0,
    out: '{regs: PMI_REG_RST, en: 1'b0}};

  pmi_lnk_type lq, ld;
  pmi_sys_type sq, sd;

  function automatic logic reg_ok(input logic [7:0] p);
    return p < 8'(PMI_NUM_REGS);
  endfunction

  function automatic logic [7:0] reg_rd(input pmi_regs_type r,
                                        input logic [7:0]   p);
    if (reg_ok(p)) begin
      return r[p[PMI_IDX_W-1:0]];
    end
    return (p == PMI_ID_PTR) ? ID_VAL : 8'h00;
  endfunction

  logic scl_c;
  logic sda_c;
  logic lrst;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic byte_done;

  assign scl_c     = lq.scl_s[1];
  assign sda_c     = lq.sda_s[1];
  assign lrst      = lq.rst_s[1];
  assign scl_rise  = scl_c & ~lq.scl_p;
  assign scl_fall  = ~scl_c & lq.scl_p;
  assign start_ev  = scl_c & lq.scl_p & lq.sda_p & ~sda_c;
  assign stop_ev   = scl_c & lq.scl_p & ~lq.sda_p & sda_c;
  assign byte_done = scl_fall & (lq.state == PMI_S_RX)
                   & (lq.cnt == PMI_BYTE_BITS);

  // link domain: serial engine and register file
  always_comb begin
    ld        = lq;
    ld.scl_s  = {lq.scl_s[0], lines.scl};
    ld.sda_s  = {lq.sda_s[0], lines.sda};
    ld.rst_s  = {lq.rst_s[0], rst};
    ld.uvlo_s = {lq.uvlo_s[0], uvlo};
    ld.ack_s  = {lq.ack_s[0], sq.ack};
    ld.scl_p  = scl_c;
    ld.sda_p  = sda_c;
    ld.pin.sda_o = 1'b0;
    // snapshot handed to system side, held until acknowledged
    if (lq.req == lq.ack_s[1]) begin
      ld.hold = lq.regs;
      ld.req  = ~lq.req;
    end
    if (lrst || lq.uvlo_s[1]) begin
      ld.state      = PMI_S_IDLE;
      ld.regs       = PMI_REG_RST;
      ld.pin.sda_oe = 1'b0;
      ld.ptr        = 8'h00;
      ld.cnt        = PMI_CNT_ZERO;
      ld.kind       = PMI_K_ADDR;
      if (lrst) begin
        ld.hold = PMI_REG_RST;
        ld.req  = 1'b0;
      end
    end else if (start_ev) begin
      // repeated start keeps the pointer
      ld.state      = PMI_S_RX;
      ld.kind       = PMI_K_ADDR;
      ld.cnt        = PMI_CNT_ZERO;
      ld.pin.sda_oe = 1'b0;
    end else if (stop_ev) begin
      ld.state      = PMI_S_IDLE;
      ld.pin.sda_oe = 1'b0;
    end else begin
      case (lq.state)
        PMI_S_RX: begin
          if (scl_rise) begin
            ld.sh  = {lq.sh[6:0], sda_c};
            ld.cnt = lq.cnt + PMI_CNT_STEP;
          end else if (byte_done) begin
            ld.state      = PMI_S_ACK;
            ld.pin.sda_oe = 1'b1;
            case (lq.kind)
              PMI_K_ADDR: begin
                ld.rw = lq.sh[0];
                if (lq.sh[7:1] != PMI_DEV_ADDR) begin
                  ld.state      = PMI_S_IDLE;
                  ld.pin.sda_oe = 1'b0;
                end
              end
              PMI_K_PTR: ld.ptr = lq.sh;
              default: begin
                if (reg_ok(lq.ptr)) begin
                  ld.regs[lq.ptr[PMI_IDX_W-1:0]] = lq.sh;
                end
                ld.ptr = lq.ptr + PMI_PTR_STEP;
              end
            endcase
          end
        end
        PMI_S_ACK: begin
          if (scl_fall) begin
            ld.pin.sda_oe = 1'b0;
            ld.cnt        = PMI_CNT_ZERO;
            if (lq.kind == PMI_K_ADDR && lq.rw) begin
              ld.state      = PMI_S_TX;
              ld.sh         = reg_rd(lq.regs, lq.ptr);
              ld.pin.sda_oe = ~ld.sh[7];
            end else begin
              ld.state = PMI_S_RX;
              ld.kind  = (lq.kind == PMI_K_ADDR) ? PMI_K_PTR
                                                 : PMI_K_DATA;
            end
          end
        end
        PMI_S_TX: begin
          if (scl_rise) begin
            ld.cnt = lq.cnt + PMI_CNT_STEP;
          end else if (scl_fall) begin
            if (lq.cnt == PMI_BYTE_BITS) begin
              ld.state      = PMI_S_MACK;
              ld.pin.sda_oe = 1'b0;
            end else begin
              ld.sh         = {lq.sh[6:0], 1'b0};
              ld.pin.sda_oe = ~lq.sh[6];
            end
          end
        end
        PMI_S_MACK: begin
          if (scl_rise) begin
            ld.mack = ~sda_c;
          end else if (scl_fall) begin
            if (lq.mack) begin
              ld.ptr        = lq.ptr + PMI_PTR_STEP;
              ld.sh         = reg_rd(lq.regs, ld.ptr);
              ld.pin.sda_oe = ~ld.sh[7];
              ld.cnt        = PMI_CNT_ZERO;
              ld.state      = PMI_S_TX;
            end else begin
              ld.state = PMI_S_IDLE;
            end
          end
        end
        default: begin
          ld.state      = PMI_S_IDLE;
          ld.pin.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_link) begin
    lq <= ld;
  end

  // system domain: registered outputs
  always_comb begin
    sd        = sq;
    sd.req_s  = {sq.req_s[0], lq.req};
    sd.uvlo_s = {sq.uvlo_s[0], uvlo};
    if (sq.req_s[1] != sq.ack) begin
      sd.out.regs = lq.hold;
      sd.ack      = sq.req_s[1];
    end
    sd.out.en = ~sq.uvlo_s[1];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sq <= PMI_SYS_RST;
    end else begin
      sq <= sd;
    end
  end

  assign ctrl  = sq.out;
  assign drive = lq.pin;

  // checks, link domain
  default clocking cb_lnk @(posedge clk_link);
  endclocking
  default disable iff (lrst);

  property p_addr_match;
    (lq.state == PMI_S_RX && lq.kind == PMI_K_ADDR && byte_done
     && !start_ev && !stop_ev && !lq.uvlo_s[1])
    |=> (lq.pin.sda_oe == ($past(lq.sh[7:1]) == PMI_DEV_ADDR));
  endproperty
  a_addr_match: assert property (p_addr_match)
    else $error("address ack does not match own address");

  property p_ack_slot;
    (lq.state == PMI_S_ACK) |-> lq.pin.sda_oe;
  endproperty
  a_ack_slot: assert property (p_ack_slot)
    else $error("ack slot not driven low");

  property p_tx_msb;
    (lq.state == PMI_S_TX && scl_rise) |-> lq.pin.sda_oe == ~lq.sh[7];
  endproperty
  a_tx_msb: assert property (p_tx_msb)
    else $error("transmit bit not msb of shifter");

  property p_drive_low;
    $rose(lq.pin.sda_oe) |-> !$past(scl_c);
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("data line taken while clock high");

  property p_idle_free;
    (lq.state == PMI_S_IDLE) |-> !lq.pin.sda_oe;
  endproperty
  a_idle_free: assert property (p_idle_free)
    else $error("data line driven while idle");

  property p_ptr_ack;
    (byte_done && lq.kind == PMI_K_PTR && !start_ev && !stop_ev
     && !lq.uvlo_s[1])
    |=> lq.state == PMI_S_ACK ##0 lq.ptr == $past(lq.sh);
  endproperty
  a_ptr_ack: assert property (p_ptr_ack)
    else $error("pointer byte not acknowledged or not loaded");

  property p_write;
    (byte_done && lq.kind == PMI_K_DATA && reg_ok(lq.ptr)
     && !start_ev && !stop_ev && !lq.uvlo_s[1])
    |=> lq.regs[$past(lq.ptr[PMI_IDX_W-1:0])] == $past(lq.sh)
        ##0 lq.ptr == $past(lq.ptr) + PMI_PTR_STEP;
  endproperty
  a_write: assert property (p_write)
    else $error("data byte not written or pointer not stepped");

  property p_uvlo;
    lq.uvlo_s[1] |=> lq.regs == PMI_REG_RST && !lq.pin.sda_oe;
  endproperty
  a_uvlo: assert property (p_uvlo)
    else $error("lockout did not restore defaults");

  property p_rd_step;
    (lq.state == PMI_S_MACK && scl_fall && lq.mack && !start_ev
     && !stop_ev && !lq.uvlo_s[1])
    |=> lq.state == PMI_S_TX ##0 lq.ptr == $past(lq.ptr) + PMI_PTR_STEP;
  endproperty
  a_rd_step: assert property (p_rd_step)
    else $error("master ack did not advance read");

  property p_discard;
    (byte_done && lq.kind == PMI_K_DATA && !reg_ok(lq.ptr)
     && !lq.uvlo_s[1]) |=> $stable(lq.regs);
  endproperty
  a_discard: assert property (p_discard)
    else $error("unimplemented pointer write changed a register");

  property p_abandon;
    (start_ev || stop_ev) && !lq.uvlo_s[1] |=> $stable(lq.regs);
  endproperty
  a_abandon: assert property (p_abandon)
    else $error("start or stop altered a register");

  c_write: cover property (byte_done && lq.kind == PMI_K_DATA);
  c_read: cover property (lq.state == PMI_S_MACK && scl_fall && lq.mack);
  c_nack: cover property (lq.state == PMI_S_MACK && scl_fall && !lq.mack);
  c_restart: cover property (start_ev && lq.state != PMI_S_IDLE);
endmodule // pmi_port

/* verification/pmi_mst.sv */
module pmi_mst (
  // link clock and resolved data wire
  input  wire logic clk_link,
  input  wire logic sda,
  // master drive, high = released
  output logic      scl,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_link);
  endtask

  // data set in low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    tick(5);
    scl <= 1'b1;
    tick(3);
    r = sda;
    tick(3);
    scl <= 1'b0;
  endtask

  // low phase long enough for the slave to release its ack first
  task automatic start;
    sda_m <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(5);
    sda_m <= 1'b0;
    tick(5);
    scl <= 1'b0;
    tick(1);
  endtask

  task automatic stop;
    sda_m <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(5);
    sda_m <= 1'b1;
    tick(5);
  endtask

  task automatic wbyte(input logic [7:0] b, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, a);
  endtask

  task automatic rbyte(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule  // pmi_mst

/* verification/tb_pmic_i2c_slave_register_port.sv */
module tb_pmic_i2c_slave_register_port;
  timeunit 1ns;
  timeprecision 1ps;
  import pmi_pkg::*;

  localparam logic [7:0] DIE_ID = 8'ha3;  // arbitrary value
  localparam logic [7:0] DEF [10] = '{8'h01, 8'hff, 8'h08, 8'h09, 8'h02,
                                      8'h0c, 8'h0e, 8'h11, 8'h16, 8'h02};
  logic        clk_sys;
  logic        clk_link;
  logic        rst;
  logic        uvlo;
  logic        scl;
  logic        sda_m;
  logic        sda;
  logic        a;
  pmi_out_type out_o;
  pmi_pin_type bus_o;
  logic [7:0]  mdl [256];
  int          miscompares;
  int          checks_done;

  assign sda = sda_m & ~(bus_o.sda_oe & ~bus_o.sda_o);

  pmi_port #(.ID_VAL(DIE_ID)) dut (
    .clk_sys(clk_sys), .rst(rst), .uvlo(uvlo), .ctrl(out_o),
    .clk_link(clk_link), .lines({scl, sda}), .drive(bus_o));
  pmi_mst m (.clk_link(clk_link), .sda(sda), .scl(scl), .sda_m(sda_m));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #3.1;
    forever #7.5 clk_link = ~clk_link;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_ack(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic chk_regs;
    repeat (40) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) chk_byte(out_o.regs[i], mdl[i]);
    chk_ack(out_o.en, ~uvlo);
  endtask

  task automatic reset_mdl;
    foreach (mdl[i]) mdl[i] = 8'h00;
    for (int i = 0; i < 10; i++) mdl[i] = DEF[i];
    mdl[8'h46] = DIE_ID;
  endtask

  task automatic hdr(input logic [7:0] p);
    m.start();
    m.wbyte(8'h7c, a);
    chk_ack(a, 1'b0);
    m.wbyte(p, a);
    chk_ack(a, 1'b0);
  endtask

  task automatic write_seq(input logic [7:0] p, input int n);
    logic [7:0] d;
    hdr(p);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      m.wbyte(d, a);
      chk_ack(a, 1'b0);
      if (p < 8'h0a) mdl[p] = d;
      p++;
    end
    m.stop();
  endtask

  task automatic read_seq(input logic [7:0] p, input int n);
    logic [7:0] d;
    hdr(p);
    m.start();
    m.wbyte(8'h7d, a);
    chk_ack(a, 1'b0);
    for (int i = 0; i < n; i++) begin
      m.rbyte(d, i == n - 1);
      chk_byte(d, mdl[p]);
      p++;
    end
    m.stop();
  endtask

  initial begin
    void'($urandom(32'h8b4d9184));
    uvlo = 1'b0;
    rst  = 1'b1;
    reset_mdl();
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    chk_regs();
    m.start();
    m.wbyte(8'h7e, a);
    chk_ack(a, 1'b1);
    m.stop();
    write_seq(8'h08, 4);
    read_seq(8'h07, 4);
    chk_regs();
    write_seq(8'hff, 2);
    read_seq(8'h45, 2);
    hdr(8'h03);
    for (int i = 0; i < 4; i++) m.bit_io(1'b0, a);
    m.stop();
    chk_regs();
    uvlo <= 1'b1;
    reset_mdl();
    chk_regs();
    m.start();
    m.wbyte(8'h7c, a);
    chk_ack(a, 1'b1);
    m.stop();
    uvlo <= 1'b0;
    chk_regs();
    for (int k = 0; k < 3; k++) begin
      logic [7:0] p;
      p = 8'($urandom % 12);
      write_seq(p, 2);
      read_seq(p, 2);
      chk_regs();
    end
    end_sim();
  end

  initial begin
    #300us;
    miscompares++;
    end_sim();
  end
endmodule  // tb_pmic_i2c_slave_register_port
